// ### rtl/dpc_pkg.sv
/*
  package for the dual-port static memory controller: pin widths, pin
  bundles, timing figures of the fastest grade and cycle counts at 100 MHz.
  assumes a 10 ns core clock and no other clock domain.
*/
`default_nettype none
package dpc_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 9;
  localparam int WORDS  = 4096;

  // ----------------------------------------------------------------
  // timing, ns as printed, and cycles at the core rate
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS            = 10;
  localparam int WRITE_CYCLE_NS           = 12;
  localparam int WRITE_PULSE_NS           = 10;
  localparam int ADDR_VALID_TO_END_NS     = 10;
  localparam int ADDR_SETUP_NS            = 0;
  localparam int WRITE_RECOVERY_NS        = 1;
  localparam int DATA_SETUP_TO_WRITE_END_NS = 8;
  localparam int DATA_HOLD_AFTER_WRITE_NS = 0;
  localparam int OUT_OFF_AFTER_WRITE_NS   = 7;
  localparam int READ_ACCESS_NS           = 12;
  localparam int OE_ACCESS_NS             = 8;
  localparam int PEER_READ_DELAY_NS       = 25;

  function automatic int ns_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // pulse: longer of pulse width and turn-off plus data setup (oe kept high anyway)
  localparam int WR_PULSE_CYC = ns_up(imax(imax(WRITE_PULSE_NS, ADDR_VALID_TO_END_NS),
                                 OUT_OFF_AFTER_WRITE_NS + DATA_SETUP_TO_WRITE_END_NS));
  localparam int WR_SETUP_CYC = ns_up(ADDR_SETUP_NS);
  localparam int WR_HOLD_CYC  = ns_up(imax(WRITE_RECOVERY_NS, DATA_HOLD_AFTER_WRITE_NS));
  localparam int WR_CYCLE_CYC = ns_up(WRITE_CYCLE_NS);
  localparam int RD_WAIT_CYC  = ns_up(imax(READ_ACCESS_NS, OE_ACCESS_NS));
  localparam int PEER_CYC     = ns_up(PEER_READ_DELAY_NS);
  localparam int CNT_W        = 4;
  localparam int SYNC_CYC     = 3;  // pin stages plus agreement filter

  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 9'h000;

  // ----------------------------------------------------------------
  // pin bundle of one memory port
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rw_sel;   // high read, low write
    logic              oe_n;
    logic [DATA_W-1:0] dout;
    logic              dout_en;
  } dpc_pins_t;

  // user request of one port
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dpc_req_t;
endpackage
`default_nettype wire

// ### rtl/dpc_port.sv
/*
  one port sequencer: turns a user request into a read or write cycle on
  the memory pins of one side.
  assumes core_clk at 100 MHz and a data input already passed through
  a three-stage synchroniser upstream.
*/
`default_nettype none
module dpc_port (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  // user side
  input  wire dpc_pkg::dpc_req_t         req,
  output logic                           ready,
  output logic                           rvalid,
  output logic [dpc_pkg::DATA_W-1:0]     rdata,
  // memory side
  input  wire logic [dpc_pkg::DATA_W-1:0] pin_din,
  output dpc_pkg::dpc_pins_t             pins
);
  typedef enum logic [2:0] {DPC_IDLE, DPC_WSET, DPC_WPULSE, DPC_WHOLD,
                            DPC_ROFF, DPC_RWAIT} dpc_state_t;
  dpc_state_t state;
  logic [dpc_pkg::CNT_W-1:0] cnt;
  logic                      write_q;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // address changes only with rw_sel high; oe high during writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state        <= DPC_IDLE;
      cnt          <= 4'h0;
      write_q      <= 1'b0;
      ready        <= 1'b0;
      rvalid       <= 1'b0;
      rdata        <= dpc_pkg::DATA_RST;
      pins.addr    <= dpc_pkg::ADDR_RST;
      pins.rw_sel  <= 1'b1;
      pins.oe_n    <= 1'b1;
      pins.dout    <= dpc_pkg::DATA_RST;
      pins.dout_en <= 1'b0;
    end else if (ce) begin
      rvalid <= 1'b0;
      case (state)
        DPC_IDLE: begin
          ready <= 1'b1;
          if (req.valid && ready) begin
            ready     <= 1'b0;
            pins.addr <= req.addr;
            write_q   <= req.write;
            cnt       <= 4'h0;
            if (req.write) begin
              pins.oe_n <= 1'b1;
              pins.dout <= req.wdata;
              state     <= DPC_WSET;
            end else begin
              pins.oe_n <= 1'b0;
              state     <= DPC_RWAIT;
            end
          end
        end
        DPC_WSET: begin
          // outputs already off (oe high), so driving data is safe
          pins.dout_en <= 1'b1;
          pins.rw_sel  <= 1'b0;
          cnt          <= 4'h1;
          state        <= DPC_WPULSE;
        end
        DPC_WPULSE: begin
          cnt <= cnt + 4'h1;
          if (cnt >= 4'(dpc_pkg::WR_PULSE_CYC)) begin
            pins.rw_sel <= 1'b1;
            cnt         <= 4'h1;
            state       <= DPC_WHOLD;
          end
        end
        DPC_WHOLD: begin
          // data and address held past end of write
          cnt <= cnt + 4'h1;
          if (cnt >= 4'(dpc_pkg::WR_HOLD_CYC)) begin
            pins.dout_en <= 1'b0;
            state        <= DPC_IDLE;
          end
        end
        DPC_RWAIT: begin
          // access time, then the synchroniser's stages before data count
          cnt <= cnt + 4'h1;
          if (cnt >= 4'(dpc_pkg::RD_WAIT_CYC + dpc_pkg::SYNC_CYC)) begin
            rdata  <= pin_din;
            rvalid <= 1'b1;
            state  <= DPC_ROFF;
          end
        end
        DPC_ROFF: begin
          pins.oe_n <= 1'b1;
          state     <= DPC_IDLE;
        end
        default: state <= DPC_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### rtl/dpc_ctrl.sv
/*
  host controller for an asynchronous dual-port static memory of 4K x 9.
  drives both ports' pins from two user request ports and keeps the two
  ports from writing one location at the same time.
  assumes one 100 MHz clock; memory read data arrive asynchronously.
*/
`default_nettype none
module dpc_ctrl (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  // left user port
  input  wire dpc_pkg::dpc_req_t          left_req,
  output logic                            left_ready,
  output logic                            left_rvalid,
  output logic [dpc_pkg::DATA_W-1:0]      left_rdata,
  // right user port
  input  wire dpc_pkg::dpc_req_t          right_req,
  output logic                            right_ready,
  output logic                            right_rvalid,
  output logic [dpc_pkg::DATA_W-1:0]      right_rdata,
  // left memory pins
  output logic [dpc_pkg::ADDR_W-1:0]      left_port_address,
  output logic                            left_rw_sel,
  output logic                            left_oe_n,
  output logic [dpc_pkg::DATA_W-1:0]      left_port_data_lines_o,
  output logic                            left_port_data_lines_oe,
  input  wire logic [dpc_pkg::DATA_W-1:0] left_port_data_lines_i,
  // right memory pins
  output logic [dpc_pkg::ADDR_W-1:0]      right_port_address,
  output logic                            right_rw_sel,
  output logic                            right_oe_n,
  output logic [dpc_pkg::DATA_W-1:0]      right_port_data_lines_o,
  output logic                            right_port_data_lines_oe,
  input  wire logic [dpc_pkg::DATA_W-1:0] right_port_data_lines_i
);
  // ----------------------------------------------------------------
  // input synchronisers, three stages per side
  // ----------------------------------------------------------------
  logic [dpc_pkg::DATA_W-1:0] l_s1, l_s2, l_s3, r_s1, r_s2, r_s3;
  logic [dpc_pkg::DATA_W-1:0] l_din, r_din;

  // three stages; a word counts once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      l_s1 <= dpc_pkg::DATA_RST; l_s2 <= dpc_pkg::DATA_RST; l_s3 <= dpc_pkg::DATA_RST;
      r_s1 <= dpc_pkg::DATA_RST; r_s2 <= dpc_pkg::DATA_RST; r_s3 <= dpc_pkg::DATA_RST;
      l_din <= dpc_pkg::DATA_RST;
      r_din <= dpc_pkg::DATA_RST;
    end else if (ce) begin
      l_s1 <= left_port_data_lines_i;
      l_s2 <= l_s1;
      l_s3 <= l_s2;
      r_s1 <= right_port_data_lines_i;
      r_s2 <= r_s1;
      r_s3 <= r_s2;
      if (l_s2 == l_s3) l_din <= l_s3;
      if (r_s2 == r_s3) r_din <= r_s3;
    end
  end

  // ----------------------------------------------------------------
  // same-address write guard
  // ----------------------------------------------------------------
  // a write to the word the other port is writing waits; left wins ties
  dpc_pkg::dpc_req_t left_gated, right_gated;
  dpc_pkg::dpc_pins_t lp, rp;
  logic l_rdy, r_rdy, l_writing, r_writing, l_clash, clash;
  logic l_wr_q, r_wr_q;

  // kind of the cycle in flight on each port
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      l_wr_q <= 1'b0;
      r_wr_q <= 1'b0;
    end else if (ce) begin
      if (left_gated.valid && l_rdy) l_wr_q <= left_gated.write;
      if (right_gated.valid && r_rdy) r_wr_q <= right_gated.write;
    end
  end

  // busy from the taking edge until ready returns, hold time included
  assign l_writing = !l_rdy && l_wr_q;
  assign r_writing = !r_rdy && r_wr_q;
  assign l_clash = left_req.write && left_req.valid &&
                   r_writing && rp.addr == left_req.addr;
  assign clash = right_req.write && right_req.valid &&
                 ((l_writing && lp.addr == right_req.addr) ||
                  (left_gated.valid && left_gated.write && l_rdy &&
                   left_req.addr == right_req.addr));

  // left request, held back while right writes its word
  always_comb begin
    left_gated       = left_req;
    left_gated.valid = left_req.valid && !l_clash;
  end

  // right request, held back while left writes or takes its word
  always_comb begin
    right_gated       = right_req;
    right_gated.valid = right_req.valid && !clash;
  end

  // ----------------------------------------------------------------
  // port sequencers
  // ----------------------------------------------------------------
  dpc_port u_left (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .req      (left_gated),
    .ready    (l_rdy),
    .rvalid   (left_rvalid),
    .rdata    (left_rdata),
    .pin_din  (l_din),
    .pins     (lp)
  );

  dpc_port u_right (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .req      (right_gated),
    .ready    (r_rdy),
    .rvalid   (right_rvalid),
    .rdata    (right_rdata),
    .pin_din  (r_din),
    .pins     (rp)
  );

  // ----------------------------------------------------------------
  // pin mapping, every pin from a sequencer flip-flop
  // ----------------------------------------------------------------
  assign left_ready               = l_rdy && !l_clash;
  assign right_ready              = r_rdy && !clash;
  assign left_port_address        = lp.addr;
  assign left_rw_sel              = lp.rw_sel;
  assign left_oe_n                = lp.oe_n;
  assign left_port_data_lines_o   = lp.dout;
  assign left_port_data_lines_oe  = lp.dout_en;
  assign right_port_address       = rp.addr;
  assign right_rw_sel             = rp.rw_sel;
  assign right_oe_n               = rp.oe_n;
  assign right_port_data_lines_o  = rp.dout;
  assign right_port_data_lines_oe = rp.dout_en;
endmodule
`default_nettype wire

// ### dv/dpc_mem_model.sv
/*
  behavioural dual-port static memory, 4K x 9, both ports asynchronous.
  assumes split data pins from the controller; index 0 left, 1 right.
*/
`default_nettype none
module dpc_mem_model #(
  parameter int RD_DLY = 8
) (
  // pins of both ports
  input  wire logic [1:0][dpc_pkg::ADDR_W-1:0] addr,
  input  wire logic [1:0]                      rw_sel,
  input  wire logic [1:0]                      oe_n,
  input  wire logic [1:0][dpc_pkg::DATA_W-1:0] dout,
  input  wire logic [1:0]                      dout_en,
  // line level seen by the controller
  output wire logic [1:0][dpc_pkg::DATA_W-1:0] din
);
  timeunit 1ns;
  timeprecision 1ps;
  // array, never cleared, no parity logic
  logic [dpc_pkg::DATA_W-1:0] mem [dpc_pkg::WORDS];
  for (genvar p = 0; p < 2; p++) begin : g_port
    logic [dpc_pkg::DATA_W-1:0] rd;
    logic [dpc_pkg::DATA_W-1:0] last = '0;
    // store while strobe low, no arbitration between ports
    always @* if (!rw_sel[p]) mem[addr[p]] = dout[p];
    // line level: controller, memory, or floating
    always_comb begin
      if (dout_en[p]) rd = dout[p];
      else if (rw_sel[p] && !oe_n[p]) rd = mem[addr[p]];
      else rd = ~last; // no keeper on the line
    end
    always @(rd) if (dout_en[p] || (rw_sel[p] && !oe_n[p])) last <= rd;
    assign #RD_DLY din[p] = rd;
  end
endmodule
`default_nettype wire

// ### dv/dpc_ctrl_checker.sv
/*
  concurrent checks on the controller's memory pins and read path.
  assumes the ports of dpc_ctrl; bound at the foot of this file.
*/
`default_nettype none
module dpc_ctrl_checker (
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       rst,
  // left side
  input wire logic [dpc_pkg::ADDR_W-1:0] left_port_address,
  input wire logic                       left_rw_sel,
  input wire logic                       left_oe_n,
  input wire logic [dpc_pkg::DATA_W-1:0] left_port_data_lines_o,
  input wire logic                       left_port_data_lines_oe,
  input wire logic [dpc_pkg::DATA_W-1:0] left_port_data_lines_i,
  input wire logic                       left_rvalid,
  input wire logic [dpc_pkg::DATA_W-1:0] left_rdata,
  // right side
  input wire logic [dpc_pkg::ADDR_W-1:0] right_port_address,
  input wire logic                       right_rw_sel,
  input wire logic                       right_oe_n,
  input wire logic [dpc_pkg::DATA_W-1:0] right_port_data_lines_o,
  input wire logic                       right_port_data_lines_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_addr_hold;
    !$stable(left_port_address) |-> left_rw_sel && $past(left_rw_sel);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("left address moved in write");
  property p_raddr_hold;
    !$stable(right_port_address) |-> right_rw_sel && $past(right_rw_sel);
  endproperty
  a_raddr_hold: assert property (p_raddr_hold) else $error("right address moved");
  property p_pulse;
    $fell(left_rw_sel) |-> !left_rw_sel [*2] ##1 left_rw_sel;
  endproperty
  a_pulse: assert property (p_pulse) else $error("left write pulse length");
  property p_rpulse;
    $fell(right_rw_sel) |-> !right_rw_sel [*2] ##1 right_rw_sel;
  endproperty
  a_rpulse: assert property (p_rpulse) else $error("right write pulse length");
  property p_drive;
    !left_rw_sel |-> left_port_data_lines_oe && left_oe_n && $stable(left_port_data_lines_o);
  endproperty
  a_drive: assert property (p_drive) else $error("left write data not driven");
  property p_rdrive;
    !right_rw_sel |-> right_port_data_lines_oe && right_oe_n && $stable(right_port_data_lines_o);
  endproperty
  a_rdrive: assert property (p_rdrive) else $error("right write data not driven");
  property p_no_clash;
    !(!left_rw_sel && !right_rw_sel && left_port_address == right_port_address);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ports write one word");
  property p_rd_lat;
    $fell(left_oe_n) |-> !left_rvalid [*6] ##1 left_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("left read latency");
  property p_rd_data;
    left_rvalid |-> !left_oe_n && left_rdata == $past(left_port_data_lines_i);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("left read data");
endmodule
bind dpc_ctrl dpc_ctrl_checker u_chk (.*);
`default_nettype wire

// ### dv/test_dpc_ctrl.sv
/*
  self-checking bench for the dual-port memory controller.
  assumes the memory model and checker compiled before it.
*/
`default_nettype none
module test_dpc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic                                core_clk = 1'b0;
  logic                                rst = 1'b1;
  logic                                ce = 1'b1;
  dpc_pkg::dpc_req_t                   req [2] = '{default: '0};
  logic [1:0]                          ready, rvalid;
  logic [1:0][dpc_pkg::DATA_W-1:0]     rdata;
  logic [dpc_pkg::ADDR_W-1:0]          left_port_address, right_port_address;
  logic                                left_rw_sel, right_rw_sel, left_oe_n, right_oe_n;
  logic [dpc_pkg::DATA_W-1:0]          left_port_data_lines_o, right_port_data_lines_o;
  logic                                left_port_data_lines_oe, right_port_data_lines_oe;
  wire  [dpc_pkg::DATA_W-1:0]          left_port_data_lines_i, right_port_data_lines_i;
  logic [dpc_pkg::DATA_W-1:0]          shadow [dpc_pkg::WORDS];
  int                                  num_errors = 0;
  int                                  samples_checked = 0;
  // clock, 10 ns period
  initial forever #5 core_clk = ~core_clk;
  dpc_ctrl dut (.*, .left_req(req[0]), .right_req(req[1]), .left_ready(ready[0]),
    .right_ready(ready[1]), .left_rvalid(rvalid[0]), .right_rvalid(rvalid[1]),
    .left_rdata(rdata[0]), .right_rdata(rdata[1]));
  dpc_mem_model #(.RD_DLY(dpc_pkg::READ_ACCESS_NS)) u_mem (
    .addr({right_port_address, left_port_address}),
    .rw_sel({right_rw_sel, left_rw_sel}),
    .oe_n({right_oe_n, left_oe_n}),
    .dout({right_port_data_lines_o, left_port_data_lines_o}),
    .dout_en({right_port_data_lines_oe, left_port_data_lines_oe}),
    .din({right_port_data_lines_i, left_port_data_lines_i}));
  function automatic logic [dpc_pkg::DATA_W-1:0] expect_word(input logic [11:0] a);
    return shadow[a];
  endfunction
  task automatic print_verdict();
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [dpc_pkg::DATA_W-1:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic limit(input int n);
    if (n >= 20) begin
      num_errors++;
      $display("[FAIL] t=%0t waited=%h limit=%h", $time, n, 20);
      print_verdict();
    end
  endtask
  // one request on port p; ready judged just before the taking edge
  task automatic access(input int p, input logic wr, input logic [11:0] a,
                        input logic [8:0] d, output logic [8:0] q);
    int n;
    @(negedge core_clk);
    req[p] = '{valid: 1'b1, write: wr, addr: a, wdata: d};
    for (n = 0; n < 20; n++) begin
      #4;
      if (ready[p] === 1'b1) break;
      @(negedge core_clk);
    end
    limit(n);
    @(negedge core_clk);
    req[p].valid = 1'b0;
    for (n = 0; n < 20 && !wr && rvalid[p] !== 1'b1; n++) @(negedge core_clk);
    limit(n);
    q = rdata[p];
  endtask
  task automatic wr(input int p, input logic [11:0] a, input logic [8:0] d);
    logic [8:0] q;
    access(p, 1'b1, a, d, q);
    shadow[a] = d;
  endtask
  task automatic rd_chk(input int p, input logic [11:0] a);
    logic [8:0] q;
    access(p, 1'b0, a, 9'h000, q);
    check(q, expect_word(a));
  endtask
  // each port owns sixteen words, so traffic never races
  task automatic rand_op(input int p);
    logic [11:0] a;
    a = {7'h00, p[0], 4'($urandom)};
    if ($isunknown(expect_word(a)) || $urandom_range(1) == 0) wr(p, a, 9'($urandom));
    else rd_chk(p, a);
  endtask
  // main sequence
  initial begin
    void'($urandom(32'h5fea151b));
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    wr(0, 12'hfff, 9'h1ff);
    rd_chk(1, 12'hfff);
    wr(1, 12'h000, 9'h100);
    rd_chk(0, 12'h000);
    // both ports write one word together; right must wait
    fork
      wr(0, 12'h055, 9'h0aa);
      wr(1, 12'h055, 9'h155);
    join
    rd_chk(0, 12'h055);
    rd_chk(1, 12'h055);
    for (int i = 0; i < 60; i++) begin
      fork
        rand_op(0);
        rand_op(1);
      join
    end
    print_verdict();
  end
endmodule
`default_nettype wire
